// ===== hw/gsp_pkg.sv
// constants and types for the gyro sample path configuration block
// Functional notes
// - Full policy 1 and queue full: further sample bytes are dropped.
// - Full policy 0 and queue full: newest byte overwrites the oldest.
// - Any frame-sync input change is latched, short strobes included.
// - Latch sampled once per period, then reloaded with present level.
// - Sampled frame-sync replaces bit 0 of the slot-selected result.
// - Filter setting applies only while both bypass bits are zero.
// - Bypass 00: 8 kHz for settings 0 and 7, 1 kHz for 1 to 6.
// - Bypass x1: 32 kHz, 8800 Hz; bypass 10: 32 kHz, 3600 Hz.
// - Range select 0..3 gives 250, 500, 1000, 2000 degrees per second.
// - Each axis self-test bit actuates its own axis while set.
// - Self-test output appears in the normal rate result registers.
// - Each source with its load bit set is copied into the queue.
// - Sensors sampled and queue loaded once per sample period.
// - Low nibble of source select, bit 7 and bit 2 have no function.
// - Filter 1 to 6: rate is 1 kHz divided by one plus divider.
// - All configuration registers reset to zero.
package gsp_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PER_1K_NS     = 1000000;
  localparam int unsigned PER_8K_NS     = 125000;
  localparam int unsigned PER_32K_NS    = 31250;
  localparam int unsigned CYC_1K        = PER_1K_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_8K        = PER_8K_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_32K       = PER_32K_NS / CLK_PERIOD_NS;
  localparam int unsigned PER_W         = 24;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_RATE_DIV   = 8'h19;
  localparam logic [7:0] IDX_PATH_CFG   = 8'h1A;
  localparam logic [7:0] IDX_RANGE_CFG  = 8'h1B;
  localparam logic [7:0] IDX_QUEUE_SRC  = 8'h23;
  localparam logic [7:0] IDX_RES_FIRST  = 8'h41;
  localparam logic [7:0] IDX_RES_LAST   = 8'h48;
  localparam logic [7:0] IDX_USER_CTL   = 8'h6A;
  localparam logic [7:0] IDX_QUEUE_CNT  = 8'h72;

  // ----------------------------------------------------------------------
  // fields, masks, reset value
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] PATH_CFG_MASK  = 8'h7F;
  localparam logic [7:0] RANGE_CFG_MASK = 8'hFB;
  localparam logic [7:0] QUEUE_SRC_MASK = 8'hF0;
  localparam logic [7:0] USER_CTL_MASK  = 8'h40;
  localparam int unsigned PC_MODE_BIT   = 6;
  localparam int unsigned PC_SLOT_LSB   = 3;
  localparam int unsigned PC_FILT_LSB   = 0;
  localparam int unsigned RC_ST_LSB     = 5;
  localparam int unsigned RC_RANGE_LSB  = 3;
  localparam int unsigned RC_BYP_LSB    = 0;
  localparam int unsigned QS_LSB        = 4;
  localparam int unsigned UC_QREAD_BIT  = 6;
  localparam logic [2:0] FILT_WIDE_LO   = 3'h0;
  localparam logic [2:0] FILT_WIDE_HI   = 3'h7;
  localparam logic [1:0] BYP_NONE       = 2'h0;

  // ----------------------------------------------------------------------
  // queue and bus
  // ----------------------------------------------------------------------
  localparam int unsigned NSRC          = 4;
  localparam int unsigned QDEPTH        = 16;
  localparam int unsigned QAW           = 4;
  localparam int unsigned QCW           = 5;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  localparam logic       HRESP_OKAY     = 1'b0;

  typedef enum logic {
    GSP_IDLE,
    GSP_LOAD
  } gsp_seq_t;

endpackage : gsp_pkg

// ===== hw/gsp_stream_if.sv
// byte stream with valid and ready between queue and output buffer
`timescale 1ns/100ps
interface gsp_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : gsp_stream_if

// ===== hw/gsp_out_buf.sv
// two-entry output buffer, all outputs registered
`timescale 1ns/100ps
module gsp_out_buf
  import gsp_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  gsp_stream_if.snk   in_s,
  gsp_stream_if.src   out_s
);

  logic       head_v_q;
  logic       tail_v_q;
  logic [7:0] head_q;
  logic [7:0] tail_q;

  wire pop_w  = head_v_q & out_s.ready;
  wire push_w = in_s.valid & ~tail_v_q;
  wire move_w = ~head_v_q | pop_w;

  assign in_s.ready  = ~tail_v_q;
  assign out_s.valid = head_v_q;
  assign out_s.data  = head_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      head_q   <= 8'h00;
      tail_q   <= 8'h00;
    end else if (move_w) begin
      head_v_q <= tail_v_q | push_w;
      head_q   <= tail_v_q ? tail_q : in_s.data;
      tail_v_q <= 1'b0;
    end else if (push_w) begin
      tail_q   <= in_s.data;
      tail_v_q <= 1'b1;
    end
  end

  // a stalled head keeps its byte
  head_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    head_v_q && !out_s.ready |=> head_v_q && head_q == $past(head_q))
    else $error("output buffer lost a stalled byte");

endmodule : gsp_out_buf

// ===== hw/gsp_sample_path.sv
// sample path configuration, sample timing and byte queue
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
module gsp_sample_path
  import gsp_pkg::*;
#(
  parameter int unsigned CYC_1K_P = CYC_1K
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] temp_raw,
  input  wire logic [15:0] x_rate_raw,
  input  wire logic [15:0] y_rate_raw,
  input  wire logic [15:0] z_rate_raw,
  input  wire logic        frame_sync_input,
  output logic             sample_strobe,
  output logic [1:0]       range_select,
  output logic [2:0]       axis_self_test,
  output logic [2:0]       filter_setting,
  output logic             low_pass_filter_en,
  output logic [1:0]       filter_bypass_select,
  output logic [7:0]       queue_data,
  output logic             queue_valid,
  input  wire logic        queue_ready
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic             hreadyout_q;
  logic [31:0]      hrdata_q;
  logic             dp_v_q;
  logic             dp_wr_q;
  logic [7:0]       dp_idx_q;
  logic [7:0]       rate_div_q;
  logic [7:0]       path_cfg_q;
  logic [7:0]       range_cfg_q;
  logic [7:0]       queue_src_q;
  logic [7:0]       user_ctl_q;
  logic [PER_W-1:0] cnt_q;
  logic             strobe_q;
  logic             fs_ref_q;
  logic             fs_chg_q;
  logic [15:0]      res_q [NSRC];
  logic             sh_mode_q;
  logic [2:0]       sh_filt_q;
  logic [1:0]       sh_byp_q;
  logic [1:0]       sh_range_q;
  logic [3:0]       sh_src_q;
  logic             lpf_en_q;
  gsp_seq_t         state_q;
  logic [2:0]       bi_q;
  logic [7:0]       mem_q [QDEPTH];
  logic [QAW-1:0]   wp_q;
  logic [QAW-1:0]   rp_q;
  logic [QCW-1:0]   qcnt_q;
  logic [15:0]      raw_w [NSRC];

  gsp_stream_if q_s ();
  gsp_stream_if o_s ();

  assign raw_w[0] = temp_raw;
  assign raw_w[1] = x_rate_raw;
  assign raw_w[2] = y_rate_raw;
  assign raw_w[3] = z_rate_raw;

  // ----------------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------------
  wire       addr_ok_w = haddr[31:10] == 22'h0;
  wire [7:0] a_idx_w   = haddr[9:2];
  wire       ap_take_w = hsel & hready & htrans[1];
  wire       wr_en_w   = dp_v_q & dp_wr_q;

  wire sel_div_w   = wr_en_w && dp_idx_q == IDX_RATE_DIV;
  wire sel_path_w  = wr_en_w && dp_idx_q == IDX_PATH_CFG;
  wire sel_range_w = wr_en_w && dp_idx_q == IDX_RANGE_CFG;
  wire sel_src_w   = wr_en_w && dp_idx_q == IDX_QUEUE_SRC;
  wire sel_uc_w    = wr_en_w && dp_idx_q == IDX_USER_CTL;

  wire [7:0] rate_div_d  = sel_div_w ? hwdata[7:0] : rate_div_q;
  wire [7:0] path_cfg_d  = sel_path_w ? (hwdata[7:0] & PATH_CFG_MASK)
                                      : path_cfg_q;
  wire [7:0] range_cfg_d = sel_range_w ? (hwdata[7:0] & RANGE_CFG_MASK)
                                       : range_cfg_q;
  wire [7:0] queue_src_d = sel_src_w ? (hwdata[7:0] & QUEUE_SRC_MASK)
                                     : queue_src_q;
  wire [7:0] user_ctl_d  = sel_uc_w ? (hwdata[7:0] & USER_CTL_MASK)
                                    : user_ctl_q;

  // result read: offset from first result index, even is high byte
  wire       res_hit_w = a_idx_w >= IDX_RES_FIRST && a_idx_w <= IDX_RES_LAST;
  wire [2:0] res_off_w = 3'(a_idx_w - IDX_RES_FIRST);
  wire [15:0] res_sel_w = res_q[res_off_w[2:1]];
  wire [7:0] res_byte_w = res_off_w[0] ? res_sel_w[7:0] : res_sel_w[15:8];

  wire [7:0] rd_byte_w =
    !addr_ok_w                   ? 8'h00 :
    a_idx_w == IDX_RATE_DIV      ? rate_div_d :
    a_idx_w == IDX_PATH_CFG      ? path_cfg_d :
    a_idx_w == IDX_RANGE_CFG     ? range_cfg_d :
    a_idx_w == IDX_QUEUE_SRC     ? queue_src_d :
    a_idx_w == IDX_USER_CTL      ? user_ctl_d :
    a_idx_w == IDX_QUEUE_CNT     ? {3'h0, qcnt_q} :
    res_hit_w                    ? res_byte_w : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_v_q   <= 1'b0;
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 8'h00;
    end else if (hready) begin
      dp_v_q   <= ap_take_w & addr_ok_w & (hsize == HSIZE_WORD);
      dp_wr_q  <= hwrite;
      dp_idx_q <= a_idx_w;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end else if (ap_take_w && !hwrite) begin
      hrdata_q    <= {24'h00_0000, rd_byte_w};
    end
  end

  // every configuration register clears to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_div_q  <= REG_RESET;
      path_cfg_q  <= REG_RESET;
      range_cfg_q <= REG_RESET;
      queue_src_q <= REG_RESET;
      user_ctl_q  <= REG_RESET;
    end else begin
      rate_div_q  <= rate_div_d;
      path_cfg_q  <= path_cfg_d;
      range_cfg_q <= range_cfg_d;
      queue_src_q <= queue_src_d;
      user_ctl_q  <= user_ctl_d;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_q;

  // ----------------------------------------------------------------------
  // sample period timer
  // ----------------------------------------------------------------------
  wire [2:0] filt_w  = path_cfg_q[PC_FILT_LSB +: 3];
  wire [1:0] byp_w   = range_cfg_q[RC_BYP_LSB +: 2];
  wire       tick_w  = cnt_q == '0;
  wire       wide_w  = filt_w == FILT_WIDE_LO || filt_w == FILT_WIDE_HI;

  wire [PER_W-1:0] per_div_w =
    PER_W'(CYC_1K_P) * (PER_W'(rate_div_q) + PER_W'(1));

  // any bypass code forces 32 kHz
  // filter 0 or 7 at 8 kHz, else 1 kHz divided by one plus divider
  wire [PER_W-1:0] per_w =
    byp_w != BYP_NONE ? PER_W'(CYC_32K) :
    wide_w            ? PER_W'(CYC_8K)  : per_div_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= '0;
      strobe_q <= 1'b0;
    end else begin
      cnt_q    <= tick_w ? per_w - PER_W'(1) : cnt_q - PER_W'(1);
      strobe_q <= tick_w;
    end
  end

  // ----------------------------------------------------------------------
  // settings shadow, taken only at the period boundary
  // ----------------------------------------------------------------------
  // shadow load at tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_mode_q  <= 1'b0;
      sh_filt_q  <= 3'h0;
      sh_byp_q   <= 2'h0;
      sh_range_q <= 2'h0;
      sh_src_q   <= 4'h0;
      lpf_en_q   <= 1'b1;
    end else if (tick_w) begin
      sh_mode_q  <= path_cfg_q[PC_MODE_BIT];
      sh_filt_q  <= filt_w;
      sh_byp_q   <= byp_w;
      sh_range_q <= range_cfg_q[RC_RANGE_LSB +: 2];
      sh_src_q   <= queue_src_q[QS_LSB +: 4];
      lpf_en_q   <= byp_w == BYP_NONE;
    end
  end

  assign low_pass_filter_en   = lpf_en_q;
  assign filter_setting       = sh_filt_q;
  assign filter_bypass_select = sh_byp_q;
  // range code to the sensor front end
  assign range_select         = sh_range_q;
  // per-axis actuation, X on bit 2
  assign axis_self_test       = range_cfg_q[RC_ST_LSB +: 3];
  assign sample_strobe        = strobe_q;

  // ----------------------------------------------------------------------
  // frame-sync latch
  // ----------------------------------------------------------------------
  wire fs_samp_w = fs_ref_q ^ fs_chg_q;

  // reload with present level at tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_ref_q <= 1'b0;
      fs_chg_q <= 1'b0;
    end else if (tick_w) begin
      fs_ref_q <= frame_sync_input;
      fs_chg_q <= 1'b0;
    end else if (frame_sync_input != fs_ref_q) begin
      fs_chg_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------------
  wire [2:0] slot_w = path_cfg_q[PC_SLOT_LSB +: 3];

  // results track the sensor, self-test included
  // frame-sync in bit 0 of slot-selected result
  for (genvar k = 0; k < NSRC; k++) begin : g_res
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        res_q[k] <= 16'h0000;
      end else if (tick_w) begin
        res_q[k] <= {raw_w[k][15:1],
                     slot_w == 3'(k + 1) ? fs_samp_w : raw_w[k][0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // queue loader
  // ----------------------------------------------------------------------
  wire [1:0] src_w     = bi_q[2:1];
  wire       src_en_w  = sh_src_q[2'(3 - src_w)];
  wire [7:0] wr_byte_w = bi_q[0] ? res_q[src_w][7:0] : res_q[src_w][15:8];

  wire wr_w = state_q == GSP_LOAD && src_en_w;

  // byte walk temp, X, Y, Z, high then low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= GSP_IDLE;
      bi_q    <= 3'h0;
    end else begin
      case (state_q)
        GSP_IDLE: begin
          if (strobe_q) begin
            state_q <= GSP_LOAD;
            bi_q    <= 3'h0;
          end
        end
        GSP_LOAD: begin
          bi_q <= bi_q + 3'h1;
          if (bi_q == 3'h7) begin
            state_q <= GSP_IDLE;
          end
        end
        default: state_q <= GSP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // byte queue
  // ----------------------------------------------------------------------
  // drain only while host read enable is set
  wire pop_w  = user_ctl_q[UC_QREAD_BIT] && qcnt_q != '0 && q_s.ready;
  wire full_w = qcnt_q == QCW'(QDEPTH) && !pop_w;
  // drop when full in stop mode
  wire drop_w = wr_w & full_w & sh_mode_q;
  // overwrite oldest when full in stream mode
  wire ovw_w  = wr_w & full_w & ~sh_mode_q;
  wire acc_w  = wr_w & ~drop_w;

  wire [QAW-1:0] wp_d = wp_q + QAW'(acc_w);
  wire [QAW-1:0] rp_d = rp_q + QAW'(pop_w | ovw_w);
  wire [QCW-1:0] qcnt_d = qcnt_q + QCW'(acc_w & ~ovw_w) - QCW'(pop_w);

  for (genvar i = 0; i < QDEPTH; i++) begin : g_mem
    always_ff @(posedge hclk) begin
      if (acc_w && wp_q == QAW'(i)) begin
        mem_q[i] <= wr_byte_w;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q   <= '0;
      rp_q   <= '0;
      qcnt_q <= '0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      qcnt_q <= qcnt_d;
    end
  end

  assign q_s.valid = user_ctl_q[UC_QREAD_BIT] && qcnt_q != '0;
  assign q_s.data  = mem_q[rp_q];
  assign o_s.ready = queue_ready;

  gsp_out_buf u_out_buf (
    .hclk    (hclk),
    .hresetn (hresetn),
    .in_s    (q_s),
    .out_s   (o_s)
  );

  assign queue_data  = o_s.data;
  assign queue_valid = o_s.valid;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  full_drop_a: assert property (
    drop_w |=> qcnt_q == QCW'(QDEPTH) && wp_q == $past(wp_q))
    else $error("queue changed while dropping on full");

  full_ovw_a: assert property (
    ovw_w |=> rp_q == $past(rp_q) + QAW'(1) && qcnt_q == $past(qcnt_q))
    else $error("oldest byte not replaced on full");

  sync_catch_a: assert property (
    !tick_w && frame_sync_input != fs_ref_q |=> fs_chg_q)
    else $error("frame-sync change not latched");

  sync_reload_a: assert property (
    tick_w |=> fs_ref_q == $past(frame_sync_input) && !fs_chg_q)
    else $error("frame-sync latch not reloaded");

  sync_slot_a: assert property (
    tick_w && slot_w == 3'h3 |=> res_q[2][0] == $past(fs_samp_w))
    else $error("frame-sync bit missing from Y result");

  lpf_gate_a: assert property (
    tick_w |=> lpf_en_q == ($past(byp_w) == BYP_NONE))
    else $error("filter enable disagrees with bypass");

  rate_8k_a: assert property (
    tick_w && byp_w == BYP_NONE && wide_w
    |=> cnt_q == PER_W'(CYC_8K - 1))
    else $error("8 kHz period wrong");

  rate_32k_a: assert property (
    tick_w && byp_w != BYP_NONE |=> cnt_q == PER_W'(CYC_32K - 1))
    else $error("32 kHz period wrong");

  rate_div_a: assert property (
    tick_w && byp_w == BYP_NONE && !wide_w
    |=> cnt_q == $past(per_div_w) - PER_W'(1))
    else $error("divided period wrong");

  load_walk_a: assert property (
    strobe_q && state_q == GSP_IDLE
    |=> state_q == GSP_LOAD && bi_q == 3'h0 ##7 bi_q == 3'h7 ##1
        state_q == GSP_IDLE)
    else $error("load walk not eight bytes");

  shadow_hold_a: assert property (
    !tick_w |=> $stable(sh_range_q) && $stable(sh_src_q))
    else $error("setting changed inside a period");

endmodule : gsp_sample_path

// ===== bench/gsp_sink_model.sv
// queue sink model: stalls at random, keeps every byte it accepts
`timescale 1ns/100ps
module gsp_sink_model (
  input  wire logic       hclk,
  input  wire logic [7:0] queue_data,
  input  wire logic       queue_valid,
  output logic            queue_ready
);
  logic [7:0] got [$];

  initial queue_ready = 1'b0;

  // stall pattern exercises the two-entry buffer
  always @(posedge hclk) begin
    if (queue_valid === 1'b1 && queue_ready)
      got.push_back(queue_data);
    queue_ready <= 1'($urandom_range(1, 0));
  end
endmodule : gsp_sink_model

// ===== bench/gyro_sample_path_config_bench.sv
// self-checking bench for the gyro sample path configuration block
`timescale 1ns/100ps
module gyro_sample_path_config_bench;
  import gsp_pkg::*;
  localparam int unsigned CYC = 50;
  localparam logic [1:0] BYP [7] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
  localparam logic [2:0] FLT [7] = '{3'h5, 3'h5, 3'h5, 3'h0, 3'h7, 3'h3, 3'h6};
  localparam logic [7:0] IDX [3] =
    '{IDX_PATH_CFG, IDX_RANGE_CFG, IDX_QUEUE_SRC};
  localparam logic [7:0] MSK [3] =
    '{PATH_CFG_MASK, RANGE_CFG_MASK, QUEUE_SRC_MASK};
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic        frame_sync_input, sample_strobe, low_pass_filter_en;
  logic        queue_valid, queue_ready;
  logic [1:0]  htrans, range_select, filter_bypass_select;
  logic [2:0]  axis_self_test, filter_setting;
  logic [7:0]  queue_data, r, p, d;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] raw [4];
  int          fail_count, compares, n;

  gsp_sample_path #(.CYC_1K_P(CYC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .temp_raw(raw[0]),
    .x_rate_raw(raw[1]), .y_rate_raw(raw[2]), .z_rate_raw(raw[3]),
    .frame_sync_input(frame_sync_input), .sample_strobe(sample_strobe),
    .range_select(range_select), .axis_self_test(axis_self_test),
    .filter_setting(filter_setting),
    .low_pass_filter_en(low_pass_filter_en),
    .filter_bypass_select(filter_bypass_select),
    .queue_data(queue_data), .queue_valid(queue_valid),
    .queue_ready(queue_ready)
  );

  gsp_sink_model SNK (
    .hclk(hclk), .queue_data(queue_data), .queue_valid(queue_valid),
    .queue_ready(queue_ready)
  );

  // ----------------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] i, input logic [7:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task rst;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : rst

  // cycles from call to the next sample pulse
  task strobe;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 3000);
  endtask : strobe

  function automatic int per(logic [7:0] rc, logic [7:0] pc, logic [7:0] dv);
    if (rc[1:0] != BYP_NONE) return CYC_32K;
    if (pc[2:0] == FILT_WIDE_LO || pc[2:0] == FILT_WIDE_HI) return CYC_8K;
    return CYC * (dv + 1);
  endfunction : per

  function automatic logic [7:0] eb(int j, int s, logic f);
    logic [15:0] w;
    w = raw[j / 2];
    if (s == j / 2 + 1) w[0] = f;
    return j[0] ? w[7:0] : w[15:8];
  endfunction : eb

  task stop_test;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    stop_test;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    frame_sync_input = 1'b0;
    raw = '{4{16'h0000}};
    fail_count = 0;
    compares = 0;
    void'($urandom(81));
    rst;
    chk(low_pass_filter_en, 1'b1);
    for (int k = 0; k < 3; k++) begin
      r = 8'($urandom);
      bus(1'b0, IDX[k], 8'h00);
      chk(rd, 32'h0);
      bus(1'b1, IDX[k], r);
      bus(1'b0, IDX[k], 8'h00);
      chk(rd, {24'h0, r & MSK[k]});
    end
    bus(1'b0, 8'h7F, 8'h00);
    chk(rd, 32'h0);
    chk(hresp, HRESP_OKAY);
    $display("test registers done");
    for (int k = 0; k < 10; k++) begin
      r = 8'($urandom);
      p = 8'($urandom);
      d = 8'($urandom_range(3, 0));
      if (k < 7) begin
        r[1:0] = BYP[k];
        p[2:0] = FLT[k];
      end
      bus(1'b1, IDX_RANGE_CFG, r);
      bus(1'b1, IDX_PATH_CFG, p);
      bus(1'b1, IDX_RATE_DIV, d);
      strobe;
      strobe;
      strobe;
      chk(n, per(r, p, d));
      chk(low_pass_filter_en, r[1:0] == BYP_NONE);
      chk(filter_bypass_select, r[1:0]);
      chk(filter_setting, p[2:0]);
      chk(range_select, r[4:3]);
      chk(axis_self_test, r[7:5]);
    end
    $display("test rates done");
    for (int s = 0; s < 6; s++) begin
      rst;
      bus(1'b1, IDX_RANGE_CFG, 8'h01);
      bus(1'b1, IDX_PATH_CFG, {2'h0, 3'(s), 3'h0});
      bus(1'b1, IDX_QUEUE_SRC, 8'hF0);
      bus(1'b1, IDX_USER_CTL, 8'h40);
      for (int t = 0; t < 2; t++) begin
        strobe;
        repeat (60) @(posedge hclk);
        SNK.got.delete();
        foreach (raw[j]) raw[j] <= 16'($urandom);
        frame_sync_input <= (t == 0);
        @(posedge hclk);
        frame_sync_input <= 1'b0;
        strobe;
        repeat (60) @(posedge hclk);
        chk(SNK.got.size(), 8);
        for (int j = 0; j < 8; j++) begin
          bus(1'b0, IDX_RES_FIRST + 8'(j), 8'h00);
          chk(rd, {24'h0, eb(j, s, t == 0)});
          chk(SNK.got[j], eb(j, s, t == 0));
        end
      end
    end
    $display("test frame sync and load order done");
    for (int q = 0; q < 2; q++) begin
      rst;
      raw[0] <= 16'h0101;
      bus(1'b1, IDX_RANGE_CFG, 8'h01);
      bus(1'b1, IDX_PATH_CFG, {1'b0, 1'(q), 6'h0});
      bus(1'b1, IDX_QUEUE_SRC, 8'h80);
      for (int k = 2; k < 12; k++) begin
        strobe;
        raw[0] <= {2{8'(k)}};
      end
      repeat (20) @(posedge hclk);
      bus(1'b0, IDX_QUEUE_CNT, 8'h00);
      chk(rd, 32'h10);
      chk(queue_valid, 1'b0);
      SNK.got.delete();
      bus(1'b1, IDX_USER_CTL, 8'h40);
      repeat (120) @(posedge hclk);
      for (int i = 0; i < 16; i++)
        chk(SNK.got[i], q ? i / 2 + 1 : i / 2 + 3);
    end
    $display("test full policy done");
    stop_test;
  end
endmodule : gyro_sample_path_config_bench
